// ===== design/ccde_exec.sv
// Execution of the clear, complement, decrement and watchdog-kick words.
// Assumes one decoded word per cycle at most and a plain register port.
// File registers power up unknown; software writes them before use.
// Operation
// - Zero-file op clears register, sets zero
// - Zero-accumulator op clears accumulator, sets zero
// - Invert op complements register, updates zero
// - Destination bit picks accumulator or register
// - Subtract-one op decrements register with wrap
// - Zero flag follows decrement result
// - Watchdog kick clears watchdog counter
// - Kick sets expiry and sleep flags
`default_nettype none
`include "ccde_params.svh"

module ccde_exec (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_in,
  input wire ccde_pkg::ccde_bus_req_t bus_req_in,
  output logic [31:0] rd_data_out,
  output logic [7:0] acc_out,
  output logic zero_flag_out,
  output logic dog_expiry_flag_out,
  output logic sleep_entered_flag_out,
  output logic exec_done_out,
  output logic unsupported_out,
  output logic wdt_timeout_out
);
  import ccde_pkg::*;

  ccde_decoded_t dec;
  logic [7:0] wdt_count;
  logic [7:0] wdt_pre;
  logic wdt_timeout;
  logic kick;

  // Data memory: 128 file registers, no reset by design
  logic [7:0] file_mem_ff [128];

  logic [7:0] acc_ff, nxt_acc;
  logic zero_ff, nxt_zero;
  logic expiry_ff, nxt_expiry;
  logic sleep_ff, nxt_sleep;
  logic file_we;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata;
  logic [7:0] operand;
  logic [7:0] result;

  logic wdt_en_ff, nxt_wdt_en;
  logic [7:0] ratio_ff, nxt_ratio;
  logic [6:0] idx_ff, nxt_idx;
  logic [31:0] exec_cnt_ff, nxt_exec_cnt;
  logic [31:0] rd_data_ff, nxt_rd_data;
  logic done_ff, nxt_done;
  logic unsup_ff, nxt_unsup;
  logic timeout_ff, nxt_timeout;
  logic op_supported;
  logic [7:0] status_byte;
  logic [7:0] file_rd_data;
  logic [31:0] rd_word;

  logic bus_wr_acc;
  logic bus_wr_status;
  logic bus_wr_file;
  logic bus_wr_ctrl;
  logic bus_wr_idx;

  // Result routing from the decoded word
  logic alu_to_acc;
  logic alu_to_file;
  logic alu_zero;

  ccde_decode u_decode (
    .instr_valid_in(instr_valid_in),
    .instr_in(instr_in),
    .dec_out(dec)
  );

  assign kick = (dec.op == OP_KICK);
  assign op_supported = (dec.op != OP_NONE);
  assign file_rd_data = file_mem_ff[idx_ff];

  ccde_watchdog u_watchdog (
    .clk_in(ref_clk_in),
    .rst_in(rst_in),
    .enable_in(wdt_en_ff),
    .ratio_in(ratio_ff),
    .kick_in(kick),
    .count_out(wdt_count),
    .prescale_out(wdt_pre),
    .timeout_out(wdt_timeout)
  );

  always_comb begin
    bus_wr_acc = bus_req_in.wr && (bus_req_in.addr == `CCDE_ACC_OFS);
    bus_wr_status = bus_req_in.wr && (bus_req_in.addr == `CCDE_STATUS_OFS);
    bus_wr_file = bus_req_in.wr && (bus_req_in.addr == `CCDE_FILE_DATA_OFS);
    bus_wr_ctrl = bus_req_in.wr && (bus_req_in.addr == `CCDE_WDT_CTRL_OFS);
    bus_wr_idx = bus_req_in.wr && (bus_req_in.addr == `CCDE_FILE_IDX_OFS);
  end

  // Result and its destination; zero follows any written result
  always_comb begin
    operand = file_mem_ff[dec.faddr];
    result = 8'h00;
    alu_to_acc = 1'b0;
    alu_to_file = 1'b0;
    case (dec.op)
      OP_ZERO_FILE: begin
        result = 8'h00;
        alu_to_file = 1'b1;
      end
      OP_ZERO_ACC: begin
        result = 8'h00;
        alu_to_acc = 1'b1;
      end
      OP_INVERT: begin
        result = ~operand;
        alu_to_file = dec.to_file;
        alu_to_acc = !dec.to_file;
      end
      OP_SUB_ONE: begin
        // Plain 8-bit subtract, so 00 wraps to ff
        result = operand - 8'h01;
        alu_to_file = dec.to_file;
        alu_to_acc = !dec.to_file;
      end
      default: begin
        result = 8'h00;
      end
    endcase
    alu_zero = (result == 8'h00);
  end

  // Datapath: accumulator, flags and file write port
  always_comb begin
    nxt_acc = acc_ff;
    nxt_zero = zero_ff;
    nxt_expiry = expiry_ff;
    nxt_sleep = sleep_ff;
    file_we = 1'b0;
    file_waddr = idx_ff;
    file_wdata = bus_req_in.wdata[7:0];

    // Software writes first; an instruction in the same cycle overrides
    if (bus_wr_acc) begin
      nxt_acc = bus_req_in.wdata[7:0];
    end
    if (bus_wr_status) begin
      nxt_zero = bus_req_in.wdata[`CCDE_ZERO_POS];
      nxt_sleep = bus_req_in.wdata[`CCDE_SLEEP_POS];
      nxt_expiry = bus_req_in.wdata[`CCDE_EXPIRY_POS];
    end
    if (bus_wr_file) begin
      file_we = 1'b1;
    end

    // Watchdog expiry drops the flag unless a kick lands alongside
    if (timeout_ff) begin
      nxt_expiry = 1'b0;
    end

    if (alu_to_acc) begin
      nxt_acc = result;
    end
    if (alu_to_file) begin
      file_we = 1'b1;
      file_waddr = dec.faddr;
      file_wdata = result;
    end
    if (alu_to_acc || alu_to_file) begin
      nxt_zero = alu_zero;
    end
    // Set wins: a kick beats both the timeout clear and software
    if (kick) begin
      nxt_expiry = 1'b1;
      nxt_sleep = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      acc_ff <= `CCDE_ACC_RST;
      zero_ff <= `CCDE_ZERO_RST;
      expiry_ff <= `CCDE_EXPIRY_RST;
      sleep_ff <= `CCDE_SLEEP_RST;
    end else begin
      acc_ff <= nxt_acc;
      zero_ff <= nxt_zero;
      expiry_ff <= nxt_expiry;
      sleep_ff <= nxt_sleep;
    end
  end

  // Memory has no reset so it maps to plain RAM
  always_ff @(posedge ref_clk_in) begin
    if (file_we) begin
      file_mem_ff[file_waddr] <= file_wdata;
    end
  end

  // Status byte as software sees it; spare bits read zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[`CCDE_ZERO_POS] = zero_ff;
    status_byte[`CCDE_SLEEP_POS] = sleep_ff;
    status_byte[`CCDE_EXPIRY_POS] = expiry_ff;
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (bus_req_in.addr == `CCDE_ACC_OFS) begin
      rd_word = {24'h00_0000, acc_ff};
    end else if (bus_req_in.addr == `CCDE_STATUS_OFS) begin
      rd_word = {24'h00_0000, status_byte};
    end else if (bus_req_in.addr == `CCDE_WDT_CNT_OFS) begin
      rd_word = {16'h0000, wdt_pre, wdt_count};
    end else if (bus_req_in.addr == `CCDE_WDT_CTRL_OFS) begin
      rd_word = {16'h0000, ratio_ff, 7'h00, wdt_en_ff};
    end else if (bus_req_in.addr == `CCDE_FILE_IDX_OFS) begin
      rd_word = {25'h000_0000, idx_ff};
    end else if (bus_req_in.addr == `CCDE_FILE_DATA_OFS) begin
      rd_word = {24'h00_0000, file_rd_data};
    end else if (bus_req_in.addr == `CCDE_EXEC_CNT_OFS) begin
      rd_word = exec_cnt_ff;
    end
  end

  // Software control state: watchdog setup and file index
  always_comb begin
    nxt_wdt_en = wdt_en_ff;
    nxt_ratio = ratio_ff;
    nxt_idx = idx_ff;
    if (bus_wr_ctrl) begin
      nxt_wdt_en = bus_req_in.wdata[`CCDE_WDT_EN_POS];
      nxt_ratio = bus_req_in.wdata[`CCDE_RATIO_LSB +: 8];
    end
    if (bus_wr_idx) begin
      nxt_idx = bus_req_in.wdata[6:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wdt_en_ff <= `CCDE_WDT_EN_RST;
      ratio_ff <= `CCDE_RATIO_RST;
      idx_ff <= `CCDE_IDX_RST;
    end else begin
      wdt_en_ff <= nxt_wdt_en;
      ratio_ff <= nxt_ratio;
      idx_ff <= nxt_idx;
    end
  end

  // Pulses, op counter and read data
  always_comb begin
    nxt_exec_cnt = exec_cnt_ff;
    nxt_rd_data = 32'h0000_0000;
    // Overflow pulse re-timed so the output leaves a flip-flop here
    nxt_timeout = wdt_timeout;
    // No stall or discard: next word may follow at once
    nxt_done = op_supported;
    nxt_unsup = dec.valid && !op_supported;
    if (op_supported) begin
      nxt_exec_cnt = exec_cnt_ff + 32'h0000_0001;
    end
    // Read data stands for one cycle only, zero otherwise
    if (bus_req_in.rd) begin
      nxt_rd_data = rd_word;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      exec_cnt_ff <= 32'h0000_0000;
      rd_data_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
      unsup_ff <= 1'b0;
      timeout_ff <= 1'b0;
    end else begin
      exec_cnt_ff <= nxt_exec_cnt;
      rd_data_ff <= nxt_rd_data;
      done_ff <= nxt_done;
      unsup_ff <= nxt_unsup;
      timeout_ff <= nxt_timeout;
    end
  end

  assign rd_data_out = rd_data_ff;
  assign acc_out = acc_ff;
  assign zero_flag_out = zero_ff;
  assign dog_expiry_flag_out = expiry_ff;
  assign sleep_entered_flag_out = sleep_ff;
  assign exec_done_out = done_ff;
  assign unsupported_out = unsup_ff;
  assign wdt_timeout_out = timeout_ff;
endmodule

`default_nettype wire

// ===== design/ccde_params.svh
// Constants for the clear/complement/decrement execution block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CCDE_PARAMS_SVH
`define CCDE_PARAMS_SVH

// Instruction encodings
`define CCDE_ZERO_FILE_TOP 7'h03
`define CCDE_INVERT_TOP 6'h09
`define CCDE_SUB_ONE_TOP 6'h03
`define CCDE_ZERO_ACC_WORD 14'h0103
`define CCDE_KICK_WORD 14'h0064
`define CCDE_DEST_BIT 7

// Register offsets (byte addresses)
`define CCDE_ACC_OFS 8'h00
`define CCDE_STATUS_OFS 8'h04
`define CCDE_WDT_CNT_OFS 8'h08
`define CCDE_WDT_CTRL_OFS 8'h0c
`define CCDE_FILE_IDX_OFS 8'h10
`define CCDE_FILE_DATA_OFS 8'h14
`define CCDE_EXEC_CNT_OFS 8'h18

// Status field positions
`define CCDE_ZERO_POS 0
`define CCDE_SLEEP_POS 3
`define CCDE_EXPIRY_POS 4

// Watchdog control field positions
`define CCDE_WDT_EN_POS 0
`define CCDE_RATIO_LSB 8

// Reset values
`define CCDE_ACC_RST 8'h00
`define CCDE_ZERO_RST 1'h0
`define CCDE_SLEEP_RST 1'h1
`define CCDE_EXPIRY_RST 1'h1
`define CCDE_WDT_EN_RST 1'h0
`define CCDE_RATIO_RST 8'hff
`define CCDE_IDX_RST 7'h00

`endif

// ===== design/ccde_pkg.sv
// Types shared by the execution block and its helpers.
// Assumes ccde_params.svh is on the include path.
`default_nettype none

package ccde_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ZERO_FILE,
    OP_ZERO_ACC,
    OP_INVERT,
    OP_SUB_ONE,
    OP_KICK
  } ccde_op_t;

  typedef struct packed {
    logic valid;
    ccde_op_t op;
    logic to_file;
    logic [6:0] faddr;
  } ccde_decoded_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ccde_bus_req_t;
endpackage

`default_nettype wire

// ===== design/ccde_decode.sv
// Pure decoder from a 14-bit program word to an operation.
// Assumes the word is held stable with its valid bit for one cycle.
`default_nettype none
`include "ccde_params.svh"

module ccde_decode (
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_in,
  output ccde_pkg::ccde_decoded_t dec_out
);
  import ccde_pkg::*;

  always_comb begin
    dec_out.valid = instr_valid_in;
    dec_out.to_file = instr_in[`CCDE_DEST_BIT];
    dec_out.faddr = instr_in[6:0];
    dec_out.op = OP_NONE;
    if (!instr_valid_in) begin
      dec_out.op = OP_NONE;
    end else if (instr_in == `CCDE_KICK_WORD) begin
      dec_out.op = OP_KICK;
    end else if (instr_in == `CCDE_ZERO_ACC_WORD) begin
      dec_out.op = OP_ZERO_ACC;
    end else if (instr_in[13:7] == `CCDE_ZERO_FILE_TOP) begin
      dec_out.op = OP_ZERO_FILE;
    end else if (instr_in[13:8] == `CCDE_INVERT_TOP) begin
      dec_out.op = OP_INVERT;
    end else if (instr_in[13:8] == `CCDE_SUB_ONE_TOP) begin
      dec_out.op = OP_SUB_ONE;
    end
  end
endmodule

`default_nettype wire

// ===== design/ccde_watchdog.sv
// Watchdog prescaler and counter with a one-cycle kick input.
// Assumes kick and enable are synchronous to clk_in.
`default_nettype none
`include "ccde_params.svh"

module ccde_watchdog (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic [7:0] ratio_in,
  input wire logic kick_in,
  output logic [7:0] count_out,
  output logic [7:0] prescale_out,
  output logic timeout_out
);
  logic [7:0] count_ff, nxt_count;
  logic [7:0] pre_ff, nxt_pre;
  logic timeout_ff, nxt_timeout;

  always_comb begin
    nxt_count = count_ff;
    nxt_pre = pre_ff;
    nxt_timeout = 1'b0;
    if (kick_in) begin
      nxt_count = 8'h00;
      nxt_pre = 8'h00;
    end else if (enable_in) begin
      // Prescaler wrap is the slow tick for the counter
      if (pre_ff >= ratio_in) begin
        nxt_pre = 8'h00;
        nxt_count = count_ff + 8'h01;
        nxt_timeout = (count_ff == 8'hff);
      end else begin
        nxt_pre = pre_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_ff <= 8'h00;
      pre_ff <= 8'h00;
      timeout_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      pre_ff <= nxt_pre;
      timeout_ff <= nxt_timeout;
    end
  end

  assign count_out = count_ff;
  assign prescale_out = pre_ff;
  assign timeout_out = timeout_ff;
endmodule

`default_nettype wire

// ===== verification/ccde_monitor.sv
// Concurrent checks on the ports of the execution block.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none

module ccde_monitor (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_in,
  input wire logic [7:0] acc_out,
  input wire logic zero_flag_out,
  input wire logic dog_expiry_flag_out,
  input wire logic sleep_entered_flag_out,
  input wire logic exec_done_out,
  input wire logic unsupported_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic zf, za, inv, sub, kick, sup;
  assign zf = instr_valid_in && instr_in[13:7] == 7'h03;
  assign za = instr_valid_in && instr_in == 14'h0103;
  assign inv = instr_valid_in && instr_in[13:8] == 6'h09;
  assign sub = instr_valid_in && instr_in[13:8] == 6'h03;
  assign kick = instr_valid_in && instr_in == 14'h0064;
  assign sup = zf || za || inv || sub || kick;
  sequence s_kick;
    kick;
  endsequence
  sequence s_flags_up;
    dog_expiry_flag_out && sleep_entered_flag_out && exec_done_out;
  endsequence
  a_zero_file: assert property (zf |=> zero_flag_out && exec_done_out)
    else $error("zero-file op left zero flag low");
  a_zero_acc: assert property (za |=> acc_out == 8'h00 && zero_flag_out)
    else $error("zero-acc op did not clear accumulator");
  a_invert_zero: assert property (inv && !instr_in[7] |=> zero_flag_out == (acc_out == 8'h00))
    else $error("invert zero flag disagrees with result");
  a_acc_kept: assert property ((inv || sub) && instr_in[7] |=> $stable(acc_out))
    else $error("file destination changed accumulator");
  a_dec_zero: assert property (sub && !instr_in[7] |=> zero_flag_out == (acc_out == 8'h00))
    else $error("decrement zero flag disagrees with result");
  a_kick_flags: assert property (s_kick |=> s_flags_up)
    else $error("kick did not raise status flags");
  a_one_cycle: assert property (sup |=> exec_done_out && !unsupported_out)
    else $error("supported op not done in one cycle");
  a_unsup_pulse: assert property (instr_valid_in && !sup |=> unsupported_out && !exec_done_out)
    else $error("unsupported word not flagged");
  a_done_cause: assert property (exec_done_out |-> $past(sup))
    else $error("done pulse without an op");
endmodule

bind ccde_exec ccde_monitor mon_u (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .instr_valid_in(instr_valid_in),
  .instr_in(instr_in),
  .acc_out(acc_out),
  .zero_flag_out(zero_flag_out),
  .dog_expiry_flag_out(dog_expiry_flag_out),
  .sleep_entered_flag_out(sleep_entered_flag_out),
  .exec_done_out(exec_done_out),
  .unsupported_out(unsupported_out)
);

`default_nettype wire

// ===== verification/ccde_tb.sv
// Self-checking bench for the execution block.
// Assumes the block alone, its ports driven straight by the bench.
`default_nettype none

module testbench import ccde_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic instr_valid_in = 1'b0;
  logic [13:0] instr_in = 14'h0000;
  ccde_bus_req_t bus_req_in = '0;
  logic [31:0] rd_data_out;
  logic [7:0] acc_out;
  logic zero_flag_out, dog_expiry_flag_out, sleep_entered_flag_out;
  logic exec_done_out, unsupported_out, wdt_timeout_out;
  int failures = 0;
  int samples_checked = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  ccde_exec dut_u (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .instr_valid_in(instr_valid_in),
    .instr_in(instr_in),
    .bus_req_in(bus_req_in),
    .rd_data_out(rd_data_out),
    .acc_out(acc_out),
    .zero_flag_out(zero_flag_out),
    .dog_expiry_flag_out(dog_expiry_flag_out),
    .sleep_entered_flag_out(sleep_entered_flag_out),
    .exec_done_out(exec_done_out),
    .unsupported_out(unsupported_out),
    .wdt_timeout_out(wdt_timeout_out)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes drop after each access so back-to-back calls never reassign in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    bus_req_in <= '0;
    @(posedge ref_clk_in);
  endtask

  task automatic rdv(input logic [7:0] a, output logic [31:0] v);
    bus_req_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    bus_req_in <= '0;
    @(posedge ref_clk_in);
    v = rd_data_out;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rdv(a, v);
    chk(v, e);
  endtask

  task automatic exec(input logic [13:0] w);
    instr_valid_in <= 1'b1;
    instr_in <= w;
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic setf(input logic [7:0] i, input logic [7:0] d);
    wr(8'h10, {24'h0, i});
    wr(8'h14, {24'h0, d});
  endtask

  task automatic st(input logic [7:0] a, input logic z);
    chk({24'h0, acc_out}, {24'h0, a});
    chk({31'h0, zero_flag_out}, {31'h0, z});
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk_in);
    failures++;
    $display("BAD %0t run did not finish", $time);
    print_verdict();
  end

  initial begin
    logic [31:0] v;
    int n;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(8'h04, 32'h18);
    rd(8'h0c, 32'hff00);
    setf(8'h05, 8'h5a);
    exec(14'h0185);
    st(8'h00, 1'b1);
    rd(8'h14, 32'h0);
    wr(8'h00, 32'h5a);
    exec(14'h0103);
    st(8'h00, 1'b1);
    setf(8'h05, 8'h13);
    exec(14'h0905);
    st(8'hec, 1'b0);
    rd(8'h14, 32'h13);
    exec(14'h0985);
    rd(8'h14, 32'hec);
    setf(8'h05, 8'hff);
    exec(14'h0905);
    st(8'h00, 1'b1);
    // Two decrements in consecutive cycles, no gap
    setf(8'h06, 8'h02);
    instr_valid_in <= 1'b1;
    instr_in <= 14'h0386;
    repeat (2) @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    @(posedge ref_clk_in);
    st(8'h00, 1'b1);
    rd(8'h14, 32'h0);
    exec(14'h0386);
    chk({31'h0, zero_flag_out}, 32'h0);
    rd(8'h14, 32'hff);
    exec(14'h0306);
    st(8'hfe, 1'b0);
    // Let the watchdog run, then freeze it so the read is stable
    wr(8'h04, 32'h0);
    wr(8'h0c, 32'h0301);
    repeat (40) @(posedge ref_clk_in);
    wr(8'h0c, 32'h0300);
    rdv(8'h08, v);
    chk({30'h0, v[15:8] != 8'h00, v[7:0] != 8'h00}, 32'h3);
    exec(14'h0064);
    chk({31'h0, exec_done_out}, 32'h1);
    rd(8'h08, 32'h0);
    chk({30'h0, dog_expiry_flag_out, sleep_entered_flag_out}, 32'h3);
    rd(8'h18, 32'ha);
    // Full speed from the kicked count: 256 counts, then two register stages
    wr(8'h0c, 32'h0001);
    n = 0;
    while (n < 300 && wdt_timeout_out !== 1'b1) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(n, 257);
    @(posedge ref_clk_in);
    chk({30'h0, wdt_timeout_out, dog_expiry_flag_out}, 32'h0);
    exec(14'h3fff);
    chk({30'h0, unsupported_out, exec_done_out}, 32'h2);
    print_verdict();
  end
endmodule

`default_nettype wire
